// *** verif/fcs_flash_model.sv ***
// Behavioural flash device that logs write cycles and answers reads
`timescale 1ns/1ps
module fcs_flash_model (
    // Flash pins
    input wire [19:0] flash_addr,
    input wire [15:0] flash_dq_out,
    input wire flash_ce_n,
    input wire flash_we_n,
    input wire flash_oe_n,
    output reg [15:0] flash_dq_in,
    output wire ready_busy_n
);
    // Arbitrary identity value
    parameter [15:0] DEV_CODE = 16'h5A3C;
    reg [19:0] wa [0:15];
    reg [15:0] wd [0:15];
    reg [19:0] lat_a;
    reg [15:0] float_pat = 16'h6C93;
    reg autosel = 1'b0;
    reg pgm = 1'b0;
    reg susp = 1'b0;
    integer n = 0;
    integer left = 0;
    wire wr = !flash_ce_n && !flash_we_n;
    assign ready_busy_n = !(left > 0 && !susp);
    always #100 if (left > 0 && !susp) left = left - 1;
    always #40 float_pat = ~float_pat;
    always @(posedge wr) lat_a = flash_addr;
    always @(negedge wr) begin
        wa[n % 16] = lat_a;
        wd[n % 16] = flash_dq_out;
        n = n + 1;
        if (pgm) begin
            pgm = 1'b0;
            left = 5;
        end else begin
            case (flash_dq_out[7:0])
                8'hA0: pgm = 1'b1;
                8'h90: autosel = 1'b1;
                8'hF0, 8'h00: autosel = 1'b0;
                8'h10: left = 20;
                8'h30: if (susp) susp = 1'b0; else left = 20;
                8'hB0: if (left > 0) susp = 1'b1;
                // other codes drop back to array read
                default: autosel = 1'b0;
            endcase
        end
    end
    always @* begin
        if (flash_ce_n || flash_oe_n)
            flash_dq_in = float_pat;
        else if (autosel && flash_addr[11:0] == 12'h001)
            flash_dq_in = DEV_CODE;
        else if (autosel && flash_addr[11:0] == 12'h002)
            flash_dq_in = {15'h0000, flash_addr[19:12] == 8'h05};
        else
            flash_dq_in = flash_addr[15:0] ^ 16'h5A5A;
    end
endmodule

// *** verif/fcs_host_monitor.sv ***
// Pin and handshake checker for the flash command host
`timescale 1ns/1ps
module fcs_host_monitor (
    // Clock and reset
    input wire clk,
    input wire resetn,
    // User side
    input wire cmd_valid,
    input wire cmd_ready,
    input wire rsp_valid,
    input wire busy,
    // Flash pins
    input wire [19:0] flash_addr,
    input wire [15:0] flash_dq_out,
    input wire flash_dq_oe_n,
    input wire flash_ce_n,
    input wire flash_we_n,
    input wire flash_oe_n,
    input wire ready_busy_n
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    // ----
    // Bus cycle shape
    // ----
    chk_no_mixed_cycle: assert property (flash_we_n || flash_oe_n)
        else $error("write and read strobes low together");
    chk_write_drives: assert property (!flash_we_n |-> !flash_dq_oe_n && !flash_ce_n)
        else $error("write strobe without chip select or data drive");
    chk_read_floats: assert property (!flash_oe_n |-> flash_dq_oe_n && !flash_ce_n)
        else $error("read strobe while host drives data");
    chk_latch_stable: assert property (!flash_we_n |-> $stable(flash_addr) && $stable(flash_dq_out))
        else $error("address or data moved under write strobe");
    chk_we_width: assert property ($fell(flash_we_n) |=> !flash_we_n ##1 flash_we_n)
        else $error("write strobe width wrong");
    chk_oe_width: assert property ($fell(flash_oe_n) |=> !flash_oe_n [*4] ##1 flash_oe_n)
        else $error("read strobe width wrong");
    // ----
    // User handshake and status
    // ----
    chk_take_drop: assert property (cmd_valid && cmd_ready |=> !cmd_ready)
        else $error("ready held after request taken");
    chk_rsp_pulse: assert property (rsp_valid |=> !rsp_valid)
        else $error("response longer than one cycle");
    chk_idle_quiet: assert property (cmd_ready |-> flash_ce_n && flash_we_n && flash_oe_n)
        else $error("bus active while idle");
    chk_busy_rise: assert property ($fell(ready_busy_n) |-> ##[1:4] busy)
        else $error("busy not raised after device busy");
    chk_busy_fall: assert property ($rose(ready_busy_n) |-> ##[1:4] !busy)
        else $error("busy not cleared after device ready");
endmodule

bind fcs_host fcs_host_monitor mon_u (.clk(clk), .resetn(resetn), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .busy(busy), .flash_addr(flash_addr),
    .flash_dq_out(flash_dq_out), .flash_dq_oe_n(flash_dq_oe_n), .flash_ce_n(flash_ce_n),
    .flash_we_n(flash_we_n), .flash_oe_n(flash_oe_n), .ready_busy_n(ready_busy_n));

// *** verif/fcs_host_tb.sv ***
// Self-checking bench for the flash command host
`timescale 1ns/1ps
module fcs_host_tb;
    reg clk = 1'b0;
    reg resetn = 1'b0;
    reg cmd_valid = 1'b0;
    reg [3:0] cmd_op = 4'h0;
    reg byte_mode = 1'b0;
    reg [19:0] cmd_addr = 20'h00000;
    reg [15:0] cmd_data = 16'h0000;
    reg [15:0] got;
    wire cmd_ready, rsp_valid, busy, suspended, flash_dq_oe_n;
    wire flash_ce_n, flash_we_n, flash_oe_n, ready_busy_n;
    wire [15:0] rsp_data, flash_dq_out, flash_dq_in;
    wire [19:0] flash_addr;
    integer err_count = 0;
    integer total_checks = 0;
    integer base = 0;
    integer cycles = 0;
    integer b;
    fcs_host dut_u (.clk(clk), .resetn(resetn), .clk_en(1'b1), .cmd_valid(cmd_valid),
        .cmd_op(cmd_op), .byte_mode(byte_mode), .cmd_addr(cmd_addr), .cmd_data(cmd_data),
        .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data), .busy(busy),
        .suspended(suspended), .flash_addr(flash_addr), .flash_dq_out(flash_dq_out),
        .flash_dq_oe_n(flash_dq_oe_n), .flash_dq_in(flash_dq_in), .flash_ce_n(flash_ce_n),
        .flash_we_n(flash_we_n), .flash_oe_n(flash_oe_n), .ready_busy_n(ready_busy_n));
    fcs_flash_model model_u (.flash_addr(flash_addr), .flash_dq_out(flash_dq_out),
        .flash_ce_n(flash_ce_n), .flash_we_n(flash_we_n), .flash_oe_n(flash_oe_n),
        .flash_dq_in(flash_dq_in), .ready_busy_n(ready_busy_n));
    initial forever #20 clk = ~clk;
    always @(posedge clk) begin
        cycles = cycles + 1;
        if (cycles == 20000) begin
            err_count = err_count + 1;
            stop_test;
        end
    end
    // ----
    // Helpers
    // ----
    task chk(input string what, input [31:0] seen, input [31:0] exp);
        begin
            total_checks = total_checks + 1;
            if (seen !== exp) begin
                err_count = err_count + 1;
                $display("MISMATCH %0s expected %h seen %h", what, exp, seen);
            end
        end
    endtask
    // One request, then count the write cycles it produced
    task op(input [3:0] o, input [19:0] a, input [15:0] d, input integer nw);
        integer i;
        begin
            base = model_u.n;
            @(posedge clk);
            while (cmd_ready !== 1'b1) @(posedge clk);
            cmd_op <= o;
            cmd_addr <= a;
            cmd_data <= d;
            cmd_valid <= 1'b1;
            @(posedge clk);
            cmd_valid <= 1'b0;
            i = 0;
            while (rsp_valid !== 1'b1 && i < 500) begin
                @(posedge clk);
                i = i + 1;
            end
            chk("rsp", rsp_valid, 1'b1);
            got = rsp_data;
            chk("writes", model_u.n - base, nw);
        end
    endtask
    task ew(input integer k, input [19:0] am, input [19:0] a, input [15:0] d);
        begin
            chk("waddr", model_u.wa[(base + k) % 16] & am, a & am);
            chk("wdata", model_u.wd[(base + k) % 16], d);
        end
    endtask
    task unl(input integer k);
        begin
            ew(k, 20'h00FFF, byte_mode ? 20'h00AAA : 20'h00555, 16'h00AA);
            ew(k + 1, 20'h00FFF, byte_mode ? 20'h00555 : 20'h002AA, 16'h0055);
        end
    endtask
    task wait_ready;
        integer i;
        begin
            repeat (5) @(posedge clk);
            chk("busy_hi", busy, 1'b1);
            i = 0;
            while (busy !== 1'b0 && i < 400) begin
                @(posedge clk);
                i = i + 1;
            end
            chk("busy_lo", busy, 1'b0);
        end
    endtask
    // ----
    // Scenarios
    // ----
    task t_read;
        begin
            op(4'h0, 20'h3A5C6, 16'h0000, 0);
            chk("array", got, 16'hFF9C);
        end
    endtask
    task t_ident;
        begin
            op(4'h2, 20'h00000, 16'h0000, 3);
            unl(0);
            ew(2, 20'h00FFF, 20'h00555, 16'h0090);
            chk("dev_id", got, 16'h5A3C);
            op(4'h1, 20'h00000, 16'h0000, 1);
            ew(0, 20'h00000, 20'h00000, 16'h00F0);
            op(4'h3, 20'h05123, 16'h0000, 3);
            chk("prot_on", got, 16'h0001);
            op(4'h3, 20'h06FFF, 16'h0000, 3);
            chk("prot_off", got, 16'h0000);
            op(4'h1, 20'h00000, 16'h0000, 1);
        end
    endtask
    task t_prog;
        begin
            op(4'h5, 20'h12345, 16'hBEEF, 4);
            unl(0);
            ew(2, 20'h00FFF, 20'h00555, 16'h00A0);
            ew(3, 20'hFFFFF, 20'h12345, 16'hBEEF);
            wait_ready;
        end
    endtask
    task t_bypass;
        begin
            op(4'h6, 20'h00000, 16'h0000, 3);
            ew(2, 20'h00FFF, 20'h00555, 16'h0020);
            op(4'h7, 20'h0ABCD, 16'h1234, 2);
            ew(0, 20'h00000, 20'h00000, 16'h00A0);
            ew(1, 20'hFFFFF, 20'h0ABCD, 16'h1234);
            wait_ready;
            op(4'h8, 20'h00000, 16'h0000, 2);
            ew(0, 20'h00000, 20'h00000, 16'h0090);
            ew(1, 20'h00000, 20'h00000, 16'h0000);
        end
    endtask
    task t_sector;
        begin
            op(4'hA, 20'h05123, 16'h0000, 6);
            ew(5, 20'hFF000, 20'h05000, 16'h0030);
            op(4'hB, 20'h07ABC, 16'h0000, 1);
            ew(0, 20'hFF000, 20'h07000, 16'h0030);
            op(4'hC, 20'h00000, 16'h0000, 1);
            ew(0, 20'h00000, 20'h00000, 16'h00B0);
            repeat (6) @(posedge clk);
            chk("susp_on", suspended, 1'b1);
            chk("susp_rdy", busy, 1'b0);
            op(4'hD, 20'h00000, 16'h0000, 1);
            ew(0, 20'h00000, 20'h00000, 16'h0030);
            chk("susp_off", suspended, 1'b0);
            wait_ready;
            op(4'hC, 20'h00000, 16'h0000, 1);
            repeat (6) @(posedge clk);
            chk("susp_idle", suspended, 1'b0);
        end
    endtask
    task t_query;
        begin
            for (b = 0; b < 2; b = b + 1) begin
                byte_mode <= b[0];
                op(4'h4, 20'h00000, 16'h0000, 1);
                ew(0, 20'h00FFF, b ? 20'h000AA : 20'h00055, 16'h0098);
            end
        end
    endtask
    task t_erase(input bm);
        begin
            byte_mode <= bm;
            op(4'h9, 20'h00000, 16'h0000, 6);
            unl(0);
            ew(2, 20'h00FFF, bm ? 20'h00AAA : 20'h00555, 16'h0080);
            unl(3);
            ew(5, 20'h00FFF, bm ? 20'h00AAA : 20'h00555, 16'h0010);
            wait_ready;
        end
    endtask
    task stop_test;
        begin
            $display("checks %0d errors %0d", total_checks, err_count);
            if (err_count == 0 && total_checks > 0)
                $display("*** PASS ***");
            else
                $display("*** FAIL ***");
            $finish;
        end
    endtask
    initial begin
        repeat (10) @(posedge clk);
        resetn <= 1'b1;
        t_read;
        t_ident;
        t_prog;
        t_bypass;
        t_sector;
        t_query;
        t_erase(1'b1);
        t_erase(1'b0);
        stop_test;
    end
endmodule

// *** verilog/fcs_bus_cycle.v ***
// One write or read cycle on the flash pins
`timescale 1ns/1ps
module fcs_bus_cycle (
    // Clock and reset
    input wire clk,
    input wire resetn,
    input wire clk_en,
    // Request
    input wire start,
    input wire is_read,
    input wire [19:0] addr,
    input wire [15:0] wdata,
    output reg done,
    output reg [15:0] rdata,
    // Flash pins
    output reg [19:0] flash_addr,
    output reg [15:0] flash_dq_out,
    output reg flash_dq_oe_n,
    input wire [15:0] flash_dq_in,
    output reg flash_ce_n,
    output reg flash_we_n,
    output reg flash_oe_n
);
`include "fcs_regs.vh"
    localparam [1:0] ST_IDLE = 2'b00;
    localparam [1:0] ST_SETUP = 2'b01;
    localparam [1:0] ST_PULSE = 2'b10;
    localparam [1:0] ST_HOLD = 2'b11;
    localparam integer PULSE_INT = `FCS_STROBE_CYC;
    localparam [3:0] PULSE_CYC = PULSE_INT[3:0];
    reg [1:0] state;
    reg [3:0] count;
    reg rd;
    reg [15:0] dq_meta;
    reg [15:0] dq_sync;
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state <= ST_IDLE;
            count <= 4'h0;
            rd <= 1'b0;
            done <= 1'b0;
            rdata <= 16'h0000;
            flash_addr <= 20'h00000;
            flash_dq_out <= 16'h0000;
            flash_dq_oe_n <= 1'b1;
            flash_ce_n <= 1'b1;
            flash_we_n <= 1'b1;
            flash_oe_n <= 1'b1;
            dq_meta <= 16'h0000;
            dq_sync <= 16'h0000;
        end else if (clk_en) begin
            dq_meta <= flash_dq_in;
            dq_sync <= dq_meta;
            done <= 1'b0;
            case (state)
                ST_IDLE: begin
                    if (start) begin
                        // Address settles before the strobes fall
                        flash_addr <= addr;
                        rd <= is_read;
                        flash_dq_out <= wdata;
                        flash_dq_oe_n <= is_read;
                        flash_ce_n <= 1'b0;
                        state <= ST_SETUP;
                    end
                end
                ST_SETUP: begin
                    flash_we_n <= rd;
                    flash_oe_n <= ~rd;
                    count <= PULSE_CYC;
                    state <= ST_PULSE;
                end
                ST_PULSE: begin
                    if (count == 4'h1) begin
                        flash_we_n <= 1'b1;
                        count <= 4'h3;
                        state <= ST_HOLD;
                    end else begin
                        count <= count - 4'h1;
                    end
                end
                ST_HOLD: begin
                    // Three extra cycles cover the input synchroniser
                    if (count == 4'h1) begin
                        rdata <= dq_sync;
                        flash_oe_n <= 1'b1;
                        flash_ce_n <= 1'b1;
                        flash_dq_oe_n <= 1'b1;
                        done <= 1'b1;
                        state <= ST_IDLE;
                    end else begin
                        count <= count - 4'h1;
                    end
                end
                default: state <= ST_IDLE;
            endcase
        end
    end
endmodule

// *** verilog/fcs_host.v ***
// Host controller that issues flash command sequences over the parallel pins
`timescale 1ns/1ps
module fcs_host (
    // Clock and reset
    input wire clk,
    input wire resetn,
    input wire clk_en,
    // User command port
    input wire cmd_valid,
    input wire [3:0] cmd_op,
    input wire byte_mode,
    input wire [19:0] cmd_addr,
    input wire [15:0] cmd_data,
    output reg cmd_ready,
    output reg rsp_valid,
    output reg [15:0] rsp_data,
    output reg busy,
    output reg suspended,
    // Flash pins
    output wire [19:0] flash_addr,
    output wire [15:0] flash_dq_out,
    output wire flash_dq_oe_n,
    input wire [15:0] flash_dq_in,
    output wire flash_ce_n,
    output wire flash_we_n,
    output wire flash_oe_n,
    input wire ready_busy_n
);
`include "fcs_regs.vh"
    // -------------------------------------------------------------
    // Operation codes
    // -------------------------------------------------------------
    localparam [3:0] OP_READ = 4'h0;
    localparam [3:0] OP_RESET = 4'h1;
    localparam [3:0] OP_DEVICE_ID = 4'h2;
    localparam [3:0] OP_PROTECT = 4'h3;
    localparam [3:0] OP_QUERY = 4'h4;
    localparam [3:0] OP_PROGRAM = 4'h5;
    localparam [3:0] OP_BYPASS_ENTER = 4'h6;
    localparam [3:0] OP_BYPASS_PROGRAM = 4'h7;
    localparam [3:0] OP_BYPASS_EXIT = 4'h8;
    localparam [3:0] OP_CHIP_ERASE = 4'h9;
    localparam [3:0] OP_SECTOR_ERASE = 4'hA;
    localparam [3:0] OP_SECTOR_ADD = 4'hB;
    localparam [3:0] OP_SUSPEND = 4'hC;
    localparam [3:0] OP_RESUME = 4'hD;
    localparam [1:0] ST_IDLE = 2'b00;
    localparam [1:0] ST_ISSUE = 2'b01;
    localparam [1:0] ST_WAIT = 2'b10;
    // -------------------------------------------------------------
    // Sequence state
    // -------------------------------------------------------------
    reg [1:0] state;
    reg [3:0] op;
    reg bm;
    reg [19:0] uaddr;
    reg [15:0] udata;
    reg [2:0] step;
    reg erasing;
    reg cyc_start;
    reg cyc_read;
    reg [19:0] cyc_addr;
    reg [15:0] cyc_wdata;
    reg rb_meta;
    reg rb_sync;
    wire cyc_done;
    wire [15:0] cyc_rdata;
    reg [2:0] last_step;
    reg [19:0] a1;
    reg [19:0] a2;
    reg [19:0] s_addr;
    reg s_read;
    reg [7:0] s_data;
    fcs_bus_cycle u_cycle (
        .clk(clk),
        .resetn(resetn),
        .clk_en(clk_en),
        .start(cyc_start),
        .is_read(cyc_read),
        .addr(cyc_addr),
        .wdata(cyc_wdata),
        .done(cyc_done),
        .rdata(cyc_rdata),
        .flash_addr(flash_addr),
        .flash_dq_out(flash_dq_out),
        .flash_dq_oe_n(flash_dq_oe_n),
        .flash_dq_in(flash_dq_in),
        .flash_ce_n(flash_ce_n),
        .flash_we_n(flash_we_n),
        .flash_oe_n(flash_oe_n)
    );
    // -------------------------------------------------------------
    // Cycle table: address, data and kind of each step
    // -------------------------------------------------------------
    always @* begin
        a1 = bm ? `FCS_ADDR_B_FIRST : `FCS_ADDR_W_FIRST;
        a2 = bm ? `FCS_ADDR_B_SECOND : `FCS_ADDR_W_SECOND;
        s_addr = a1;
        s_read = 1'b0;
        s_data = `FCS_CMD_UNLOCK1;
        last_step = 3'd0;
        // Unlock pattern shared by the long sequences
        if (step == 3'd1 || step == 3'd4) begin
            s_addr = a2;
            s_data = `FCS_CMD_UNLOCK2;
        end
        case (op)
            OP_READ: begin
                s_read = 1'b1;
                s_addr = uaddr;
            end
            OP_RESET: begin
                s_data = `FCS_CMD_RESET;
            end
            OP_DEVICE_ID, OP_PROTECT: begin
                last_step = 3'd3;
                if (step == 3'd2) begin
                    s_data = `FCS_CMD_AUTOSEL;
                end else if (step == 3'd3) begin
                    s_read = 1'b1;
                    if (op == OP_DEVICE_ID) begin
                        s_addr = bm ? `FCS_ADDR_B_DEVICE : `FCS_ADDR_W_DEVICE;
                    end else begin
                        a2 = bm ? `FCS_ADDR_B_PROTECT : `FCS_ADDR_W_PROTECT;
                        s_addr = {uaddr[`FCS_SECTOR_MSB:`FCS_SECTOR_LSB], a2[11:0]};
                    end
                end
            end
            OP_QUERY: begin
                s_addr = bm ? `FCS_ADDR_B_QUERY : `FCS_ADDR_W_QUERY;
                s_data = `FCS_CMD_QUERY;
            end
            OP_PROGRAM, OP_BYPASS_ENTER: begin
                last_step = (op == OP_PROGRAM) ? 3'd3 : 3'd2;
                if (step == 3'd2) begin
                    s_data = (op == OP_PROGRAM) ? `FCS_CMD_PROGRAM : `FCS_CMD_BYPASS;
                end else if (step == 3'd3) begin
                    s_addr = uaddr;
                end
            end
            OP_BYPASS_PROGRAM, OP_BYPASS_EXIT: begin
                last_step = 3'd1;
                s_addr = (op == OP_BYPASS_PROGRAM && step == 3'd1) ? uaddr : 20'h00000;
                if (op == OP_BYPASS_PROGRAM) begin
                    s_data = (step == 3'd0) ? `FCS_CMD_PROGRAM : 8'h00;
                end else begin
                    s_data = (step == 3'd0) ? `FCS_CMD_AUTOSEL : `FCS_CMD_BYPASS_EXIT2;
                end
            end
            OP_CHIP_ERASE, OP_SECTOR_ERASE: begin
                last_step = 3'd5;
                if (step == 3'd2) begin
                    s_data = `FCS_CMD_ERASE_SETUP;
                end else if (step == 3'd5) begin
                    if (op == OP_CHIP_ERASE) begin
                        s_data = `FCS_CMD_CHIP_ERASE;
                    end else begin
                        s_addr = uaddr;
                        s_data = `FCS_CMD_SECTOR_ERASE;
                    end
                end
            end
            OP_SECTOR_ADD: begin
                s_addr = uaddr;
                s_data = `FCS_CMD_SECTOR_ERASE;
            end
            OP_SUSPEND: begin
                s_data = `FCS_CMD_SUSPEND;
            end
            OP_RESUME: begin
                s_data = `FCS_CMD_RESUME;
            end
            default: begin
                s_data = `FCS_CMD_RESET;
            end
        endcase
    end
    // -------------------------------------------------------------
    // Sequencer
    // -------------------------------------------------------------
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state <= ST_IDLE;
            op <= OP_READ;
            bm <= 1'b0;
            uaddr <= 20'h00000;
            udata <= 16'h0000;
            step <= 3'd0;
            erasing <= 1'b0;
            cyc_start <= 1'b0;
            cyc_read <= 1'b0;
            cyc_addr <= 20'h00000;
            cyc_wdata <= 16'h0000;
            cmd_ready <= 1'b0;
            rsp_valid <= 1'b0;
            rsp_data <= 16'h0000;
            busy <= 1'b0;
            suspended <= 1'b0;
            rb_meta <= 1'b1;
            rb_sync <= 1'b1;
        end else if (clk_en) begin
            rb_meta <= ready_busy_n;
            rb_sync <= rb_meta;
            busy <= ~rb_sync;
            cyc_start <= 1'b0;
            rsp_valid <= 1'b0;
            case (state)
                ST_IDLE: begin
                    cmd_ready <= 1'b1;
                    if (cmd_valid && cmd_ready) begin
                        cmd_ready <= 1'b0;
                        op <= cmd_op;
                        bm <= byte_mode;
                        uaddr <= cmd_addr;
                        udata <= cmd_data;
                        step <= 3'd0;
                        state <= ST_ISSUE;
                    end
                end
                ST_ISSUE: begin
                    cyc_start <= 1'b1;
                    cyc_read <= s_read;
                    cyc_addr <= s_addr;
                    // Program data uses both bytes; command writes only the low byte
                    if ((op == OP_PROGRAM && step == 3'd3) ||
                        (op == OP_BYPASS_PROGRAM && step == 3'd1)) begin
                        cyc_wdata <= udata;
                    end else begin
                        cyc_wdata <= {8'h00, s_data};
                    end
                    state <= ST_WAIT;
                end
                ST_WAIT: begin
                    if (cyc_done) begin
                        if (step == last_step) begin
                            rsp_valid <= 1'b1;
                            rsp_data <= cyc_rdata;
                            if (op == OP_SECTOR_ERASE) begin
                                erasing <= 1'b1;
                            end else if (op == OP_SUSPEND && erasing) begin
                                suspended <= 1'b1;
                            end else if (op == OP_RESUME && suspended) begin
                                suspended <= 1'b0;
                            end
                            if (op == OP_CHIP_ERASE || op == OP_RESET) begin
                                erasing <= 1'b0;
                            end
                            state <= ST_IDLE;
                        end else begin
                            step <= step + 3'd1;
                            state <= ST_ISSUE;
                        end
                    end
                end
                default: state <= ST_IDLE;
            endcase
            if (rb_sync && !suspended && state == ST_IDLE) begin
                erasing <= 1'b0;
            end
        end
    end
endmodule

// *** verilog/fcs_regs.vh ***
// Command codes, unlock addresses and bus timing for the flash command host
`ifndef FCS_REGS_VH
`define FCS_REGS_VH
`define FCS_CMD_UNLOCK1 8'hAA
`define FCS_CMD_UNLOCK2 8'h55
`define FCS_CMD_AUTOSEL 8'h90
`define FCS_CMD_PROGRAM 8'hA0
`define FCS_CMD_BYPASS 8'h20
`define FCS_CMD_ERASE_SETUP 8'h80
`define FCS_CMD_CHIP_ERASE 8'h10
`define FCS_CMD_SECTOR_ERASE 8'h30
`define FCS_CMD_SUSPEND 8'hB0
`define FCS_CMD_RESUME 8'h30
`define FCS_CMD_QUERY 8'h98
`define FCS_CMD_RESET 8'hF0
`define FCS_CMD_BYPASS_EXIT2 8'h00
`define FCS_ADDR_W_FIRST 20'h00555
`define FCS_ADDR_W_SECOND 20'h002AA
`define FCS_ADDR_B_FIRST 20'h00AAA
`define FCS_ADDR_B_SECOND 20'h00555
`define FCS_ADDR_W_QUERY 20'h00055
`define FCS_ADDR_B_QUERY 20'h000AA
`define FCS_ADDR_W_DEVICE 20'h00001
`define FCS_ADDR_B_DEVICE 20'h00002
`define FCS_ADDR_W_PROTECT 20'h00002
`define FCS_ADDR_B_PROTECT 20'h00004
`define FCS_SECTOR_MSB 19
`define FCS_SECTOR_LSB 12
`define FCS_STROBE_NS 80
`define FCS_CLK_NS 40
`define FCS_STROBE_CYC ((`FCS_STROBE_NS + `FCS_CLK_NS - 1) / `FCS_CLK_NS)
`endif
